// *** logic/ddc_regs.vh ***
/*
 Constants for the synthesizer core, clock selection and serial control port.
 Assumes inclusion by ddc_core_clock_select.v and by the testbench.
*/
`ifndef DDC_REGS_VH
`define DDC_REGS_VH
// Serial addresses
`define DDC_ADDR_CTRL1      5'h00
`define DDC_ADDR_CTRL2      5'h01
`define DDC_ADDR_TUNING     5'h04
// Control register one fields
`define DDC_C1_LSB_FIRST    0
`define DDC_C1_SDIO_ONLY    1
`define DDC_C1_CLR_PHASE    2
`define DDC_C1_CLK_PD       4
// Control register two fields
`define DDC_C2_MULT_HI      7
`define DDC_C2_MULT_LO      3
`define DDC_C2_XTAL_OUT     9
// Reset values
`define DDC_CTRL1_RST       32'h0000_0000
`define DDC_CTRL1_ACT_RST   32'h0000_0004
`define DDC_CTRL2_RST       24'h00_0000
`define DDC_TUNING_RST      32'h0000_0000
// Multiplier range
`define DDC_MULT_MIN        5'h04
`define DDC_MULT_MAX        5'h14
// Widths
`define DDC_ACC_W           32
`define DDC_DAC_W           14
`endif

// *** logic/ddc_core_clock_select.v ***
/*
 Synthesizer core: phase accumulator, cosine lookup, 14-bit sample out,
 clock mode selection outputs and a serial control port (2- or 3-wire).
 Assumes clk is the core sample clock; serial pins are asynchronous and
 are sampled with two flip-flops; update strobe arrives from outside.
*/
`timescale 1ns/1ps
`include "ddc_regs.vh"

// Function
// (RULE1) Accumulator is 32 bits; output frequency is tuning word times clock over 2^32.
// (RULE2) Each cycle add tuning word modulo 2^32 unless clear holds zero.
// (RULE3) Accumulator phase passes through a cosine lookup to the converter.
// (RULE4) Converter sample is fourteen bits, one per clock.
// (RULE5) Zero tuning word holds the present phase, no return to zero.
// (RULE6) Clear-phase bit forces accumulator output to zero while set.
// (RULE7) Reset: active clear bit one, buffered copy zero until first update.
// (RULE8) Multiplier field is control register two bits seven to three.
// (RULE9) Field values 0x04 to 0x14 multiply reference by that value.
// (RULE10) Host keeps multiplied clock at or below 400 MHz.
// (RULE11) Host waits about 1 ms for lock after multiplier change.
// (RULE12) Field outside 4..20 bypasses and powers down the multiplier.
// (RULE13) Oscillator select pin high enables oscillator; low disables oscillator and buffer.
// (RULE14) Control one bit four stops clock input buffer; oscillator keeps running.
// (RULE15) Control two bit nine enables crystal output buffer.
// (RULE16) Multiplier setting independent of clock input power-down bit.
// (RULE17) Serial port reads and writes all registers, MSB or LSB first.
// (RULE18) Port uses one bidirectional data pin or separate in and out pins.
// (RULE19) Abort input high resets the port controller at once; the code resets it only after the two-flop synchroniser.
// (RULE20) Port responds only while active-low chip select is low.
module ddc_core_clock_select (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        osc_select_pin,
    input  wire        io_update,
    input  wire        port_abort_input,
    input  wire        chip_select_n,
    input  wire        serial_clock,
    input  wire        serial_data_in,
    output reg         serial_data_oe,
    output reg         serial_data_io,
    output reg         serial_data_out,
    output reg  [13:0] dac_sample,
    output reg  [4:0]  pll_multiplier,
    output reg         pll_enable,
    output reg         osc_enable,
    output reg         clock_input_enable,
    output reg         crystal_out_enable,
    output reg  [31:0] phase_out
);
    localparam ST_INSTR = 2'b00;
    localparam ST_DATA  = 2'b01;
    localparam ST_DONE  = 2'b10;

    // Buffered (serial) and active register copies
    reg  [31:0] bufCtrl1;
    reg  [23:0] bufCtrl2;
    reg  [31:0] bufTuning;
    reg  [31:0] ctrl1;
    reg  [23:0] ctrl2;
    reg  [31:0] tuning;
    reg  [31:0] phaseAcc;
    // Synchronisers
    reg  [1:0]  sclkSync;
    reg  [1:0]  csSync;
    reg  [1:0]  sdiSync;
    reg  [1:0]  abortSync;
    reg  [1:0]  updSync;
    reg  [1:0]  oscSync;
    reg         sclkPrev;
    reg         updPrev;
    // Serial engine
    reg  [1:0]  state;
    reg  [5:0]  bitCnt;
    reg  [7:0]  instr;
    reg  [31:0] shiftIn;
    reg  [31:0] shiftOut;
    reg  [5:0]  wordLen;

    wire sclkRise  = sclkSync[1] & ~sclkPrev;
    wire sclkFall  = ~sclkSync[1] & sclkPrev;
    wire updRise   = updSync[1] & ~updPrev;
    wire portIdle  = csSync[1] | abortSync[1];
    wire lsbFirst  = ctrl1[`DDC_C1_LSB_FIRST];
    wire threeWire = ctrl1[`DDC_C1_SDIO_ONLY];
    wire isRead    = instr[7];
    wire [4:0] regAddr = instr[4:0];
    wire [4:0] multField = ctrl2[`DDC_C2_MULT_HI:`DDC_C2_MULT_LO];

    // Bit count of each register
    function [5:0] reg_bits;
        input [4:0] addr;
        begin
            case (addr)
                `DDC_ADDR_CTRL2: reg_bits = 6'h18;
                default:         reg_bits = 6'h20;
            endcase
        end
    endfunction

    // Parabolic cosine, quarter-turn shifted; peak stays inside 14 bits
    function [13:0] cos_lookup;
        input [7:0] idx;
        reg   [7:0] s;
        reg   [7:0] q;
        reg  [13:0] mag;
        begin
            s   = idx + 8'h40;
            q   = s[6] ? ~s : s;
            mag = {1'b0, q[5:0], 7'h00} - ({8'h00, q[5:0]} * {8'h00, q[5:0]});
            cos_lookup = s[7] ? (14'h2000 - mag) : (14'h2000 + mag);
        end
    endfunction

    function [31:0] read_value;
        input [4:0] addr;
        begin
            case (addr)
                `DDC_ADDR_CTRL1:  read_value = ctrl1;
                `DDC_ADDR_CTRL2:  read_value = {8'h00, ctrl2};
                `DDC_ADDR_TUNING: read_value = tuning;
                default:          read_value = 32'h0000_0000;
            endcase
        end
    endfunction

    function [31:0] bit_reverse;
        input [31:0] v;
        input [5:0]  len;
        integer i;
        begin
            bit_reverse = 32'h0000_0000;
            for (i = 0; i < 32; i = i + 1) begin
                if (i < len)
                    bit_reverse[len - 1 - i] = v[i];
            end
        end
    endfunction

    wire [31:0] revIn = bit_reverse(shiftIn, 6'h20);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclkSync  <= 2'b00;
            csSync    <= 2'b11;
            sdiSync   <= 2'b00;
            abortSync <= 2'b00;
            updSync   <= 2'b00;
            oscSync   <= 2'b00;
            sclkPrev  <= 1'b0;
            updPrev   <= 1'b0;
        end else begin
            sclkSync  <= {sclkSync[0], serial_clock};
            csSync    <= {csSync[0], chip_select_n};
            sdiSync   <= {sdiSync[0], serial_data_in};
            abortSync <= {abortSync[0], port_abort_input};
            updSync   <= {updSync[0], io_update};
            oscSync   <= {oscSync[0], osc_select_pin};
            sclkPrev  <= sclkSync[1];
            updPrev   <= updSync[1];
        end
    end

    // Serial port engine
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state          <= ST_INSTR;
            bitCnt         <= 6'h00;
            instr          <= 8'h00;
            shiftIn        <= 32'h0000_0000;
            shiftOut       <= 32'h0000_0000;
            wordLen        <= 6'h00;
            bufCtrl1       <= `DDC_CTRL1_RST;
            bufCtrl2       <= `DDC_CTRL2_RST;
            bufTuning      <= `DDC_TUNING_RST;
            serial_data_oe <= 1'b0;
            serial_data_io <= 1'b0;
            serial_data_out <= 1'b0;
        end else if (portIdle) begin
            state          <= ST_INSTR; // RULE19 RULE20
            bitCnt         <= 6'h00;
            wordLen        <= 6'h00;
            serial_data_oe <= 1'b0;
        end else begin
            case (state)
                ST_INSTR: begin
                    if (sclkRise) begin
                        instr  <= lsbFirst ? {sdiSync[1], instr[7:1]}
                                           : {instr[6:0], sdiSync[1]}; // RULE17
                        bitCnt <= bitCnt + 6'h01;
                        if (bitCnt == 6'h07) begin
                            state   <= ST_DATA;
                            bitCnt  <= 6'h00;
                        end
                    end
                end
                ST_DATA: begin
                    if (bitCnt == 6'h00 && wordLen != reg_bits(regAddr)) begin
                        wordLen  <= reg_bits(regAddr);
                        shiftOut <= lsbFirst ? read_value(regAddr)
                            : bit_reverse(read_value(regAddr), reg_bits(regAddr));
                    end
                    if (isRead && sclkFall) begin
                        serial_data_out <= shiftOut[0]; // RULE18
                        serial_data_io  <= shiftOut[0];
                        serial_data_oe  <= ~threeWire;
                        shiftOut        <= {1'b0, shiftOut[31:1]};
                    end
                    if (sclkRise) begin
                        shiftIn <= {sdiSync[1], shiftIn[31:1]};
                        bitCnt  <= bitCnt + 6'h01;
                        if (bitCnt == wordLen - 6'h01)
                            state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (!isRead) begin
                        case (regAddr)
                            `DDC_ADDR_CTRL1:  bufCtrl1  <= lsbFirst ? shiftIn : revIn;
                            `DDC_ADDR_CTRL2:  bufCtrl2  <= lsbFirst ? shiftIn[31:8]
                                : revIn[23:0]; // RULE17
                            `DDC_ADDR_TUNING: bufTuning <= lsbFirst ? shiftIn : revIn;
                            default: ;
                        endcase
                    end
                    wordLen        <= 6'h00;
                    bitCnt         <= 6'h00;
                    serial_data_oe <= 1'b0;
                    state          <= ST_INSTR;
                end
                default: state <= ST_INSTR;
            endcase
        end
    end

    // Update transfers buffers; clear bit starts set, buffer starts clear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1  <= `DDC_CTRL1_ACT_RST; // RULE7
            ctrl2  <= `DDC_CTRL2_RST;
            tuning <= `DDC_TUNING_RST;
        end else if (updRise) begin
            ctrl1  <= bufCtrl1;
            ctrl2  <= bufCtrl2;
            tuning <= bufTuning;
        end
    end

    // Phase accumulator and sample path
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phaseAcc   <= 32'h0000_0000;
            phase_out  <= 32'h0000_0000;
            dac_sample <= 14'h0000;
        end else begin
            if (ctrl1[`DDC_C1_CLR_PHASE])
                phaseAcc <= 32'h0000_0000; // RULE6
            else
                phaseAcc <= phaseAcc + tuning; // RULE1 RULE2 RULE5
            phase_out  <= phaseAcc;
            dac_sample <= cos_lookup(phaseAcc[31:24]); // RULE3 RULE4
        end
    end

    // Clock selection controls
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_multiplier     <= 5'h00;
            pll_enable         <= 1'b0;
            osc_enable         <= 1'b0;
            clock_input_enable <= 1'b1;
            crystal_out_enable <= 1'b0;
        end else begin
            pll_multiplier <= multField; // RULE8 RULE16
            pll_enable     <= (multField >= `DDC_MULT_MIN) &&
                              (multField <= `DDC_MULT_MAX); // RULE9 RULE12
            osc_enable     <= oscSync[1]; // RULE13 RULE14
            clock_input_enable <= ~ctrl1[`DDC_C1_CLK_PD]; // RULE14
            crystal_out_enable <= oscSync[1] & ctrl2[`DDC_C2_XTAL_OUT]; // RULE13 RULE15
        end
    end
endmodule // ddc_core_clock_select

// *** verification/ddc_monitor.sv ***
/* Port checker for the synthesizer core and its clock selection outputs.
   Assumes it is bound to ddc_core_clock_select and sees only its ports. */
`timescale 1ns/1ps
module ddc_monitor (
    input wire        clk,
    input wire        rst_n,
    input wire        osc_select_pin,
    input wire        io_update,
    input wire        port_abort_input,
    input wire        chip_select_n,
    input wire        serial_data_oe,
    input wire [13:0] dac_sample,
    input wire [4:0]  pll_multiplier,
    input wire        pll_enable,
    input wire        osc_enable,
    input wire        clock_input_enable,
    input wire        crystal_out_enable,
    input wire [31:0] phase_out
);
    logic [3:0] quiet;
    logic       updSeen;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Cycles since the last update request, saturating
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            quiet   <= 4'h0;
            updSeen <= 1'b0;
        end else begin
            quiet   <= io_update ? 4'h0 : (quiet == 4'hF ? quiet : quiet + 4'h1);
            updSeen <= updSeen | io_update;
        end
    end
    property p_clear; !updSeen |-> phase_out == 32'h0000_0000; endproperty
    a_clear: assert property (p_clear) else $error("phase moved before update");
    property p_step;
        quiet == 4'hF && phase_out != 0 && $past(phase_out) != 0 && $past(phase_out, 2) != 0
        |-> phase_out - $past(phase_out) == $past(phase_out) - $past(phase_out, 2);
    endproperty
    a_step: assert property (p_step) else $error("phase step not constant");
    property p_dac;
        quiet == 4'hF && $stable(phase_out) && $past(phase_out) == $past(phase_out, 2)
        |=> $stable(dac_sample);
    endproperty
    a_dac: assert property (p_dac) else $error("sample moved on still phase");
    property p_pll; pll_enable == (pll_multiplier >= 5'h04 && pll_multiplier <= 5'h14); endproperty
    a_pll: assert property (p_pll) else $error("multiplier enable wrong");
    property p_osc; $rose(osc_select_pin) |-> ##[1:4] osc_enable; endproperty
    a_osc: assert property (p_osc) else $error("oscillator not enabled");
    property p_xtal; $fell(osc_enable) |-> ##[0:3] !crystal_out_enable; endproperty
    a_xtal: assert property (p_xtal) else $error("crystal buffer left on");
    property p_ce; $changed(clock_input_enable) |-> quiet <= 4'h6; endproperty
    a_ce: assert property (p_ce) else $error("clock buffer changed without update");
    property p_abort; port_abort_input [*3] |=> !serial_data_oe; endproperty
    a_abort: assert property (p_abort) else $error("port drives during abort");
    property p_cs; chip_select_n [*3] |=> !serial_data_oe; endproperty
    a_cs: assert property (p_cs) else $error("port drives while deselected");
    c_upd: cover property (io_update);
    c_pll: cover property (pll_enable);
    c_oe: cover property (serial_data_oe);
endmodule // ddc_monitor
bind ddc_core_clock_select ddc_monitor mon (.clk(clk), .rst_n(rst_n),
    .osc_select_pin(osc_select_pin), .io_update(io_update),
    .port_abort_input(port_abort_input), .chip_select_n(chip_select_n),
    .serial_data_oe(serial_data_oe), .dac_sample(dac_sample),
    .pll_multiplier(pll_multiplier), .pll_enable(pll_enable), .osc_enable(osc_enable),
    .clock_input_enable(clock_input_enable), .crystal_out_enable(crystal_out_enable),
    .phase_out(phase_out));

// *** verification/ddc_host_model.sv ***
/* Host controller model driving the serial control port.
   Assumes the bench resolves the shared data line and feeds it back. */
`timescale 1ns/1ps
module ddc_host_model (
    output logic chipSelectN,
    output logic serialClock,
    output logic hostData,
    input  wire  lineData
);
    initial begin
        chipSelectN = 1'b1;
        serialClock = 1'b0;
        hostData    = 1'b0;
    end
    // Serial clock idles low; data set on falling, read on rising
    task automatic shift(input logic lsb, input logic [31:0] v, input int n,
                         output logic [31:0] got);
        int k;
        got = 32'h0000_0000;
        for (int i = 0; i < n; i++) begin
            k = lsb ? i : n - 1 - i;
            hostData = v[k];
            #32 serialClock = 1'b1;
            got[k] = lineData;
            #32 serialClock = 1'b0;
        end
    endtask
    task automatic xfer(input logic sel, input logic lsb, input logic [7:0] ins,
                        input logic [31:0] v, input int n, output logic [31:0] got);
        logic [31:0] dummy;
        chipSelectN = ~sel;
        #32;
        shift(lsb, {24'h00_0000, ins}, 8, dummy);
        shift(lsb, v, n, got);
        #32 chipSelectN = 1'b1;
        hostData = ~hostData;
        #64;
    endtask
endmodule // ddc_host_model

// *** verification/ddc_core_clock_select_tb.sv ***
/* Self-checking bench for the synthesizer core.
   Assumes the host model and the bound port checker. */
`timescale 1ns/1ps
`include "ddc_regs.vh"
`define CHK(nm, exp, got) begin totalChecks++; if ((got) !== (exp)) begin errorCnt++; \
    $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module ddc_core_clock_select_tb;
    logic        clk, rst_n, oscSel, ioUpdate, abortIn, threeWire, lsb;
    wire         csN, sclk, hostData, sdioLine, rdLine, sdioOe, sdioOut, sdoOut;
    wire         pllEn, oscEn, clkInEn, xtalEn;
    wire  [13:0] dac;
    wire  [4:0]  mult;
    wire  [31:0] phase;
    logic [31:0] got, p0, p1;
    int          errorCnt = 0;
    int          totalChecks = 0;
    int          mv[6] = '{0, 3, 4, 20, 21, 31};
    assign sdioLine = sdioOe ? sdioOut : hostData;
    assign rdLine   = threeWire ? sdoOut : sdioLine;
    ddc_host_model host (.chipSelectN(csN), .serialClock(sclk), .hostData(hostData),
        .lineData(rdLine));
    ddc_core_clock_select dut (.clk(clk), .rst_n(rst_n), .osc_select_pin(oscSel),
        .io_update(ioUpdate), .port_abort_input(abortIn), .chip_select_n(csN),
        .serial_clock(sclk), .serial_data_in(sdioLine), .serial_data_oe(sdioOe),
        .serial_data_io(sdioOut), .serial_data_out(sdoOut), .dac_sample(dac),
        .pll_multiplier(mult), .pll_enable(pllEn), .osc_enable(oscEn),
        .clock_input_enable(clkInEn), .crystal_out_enable(xtalEn), .phase_out(phase));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic wr(input logic [4:0] a, input logic [31:0] v, input int n);
        host.xfer(1'b1, lsb, {3'h0, a}, v, n, got);
        @(negedge clk);
    endtask
    task automatic rd(input logic [4:0] a, input int n);
        host.xfer(1'b1, lsb, {3'h4, a}, 32'hFFFF_FFFF, n, got);
        @(negedge clk);
    endtask
    task automatic upd;
        @(negedge clk) ioUpdate = 1'b1;
        repeat (2) @(negedge clk);
        ioUpdate = 1'b0;
        repeat (8) @(negedge clk);
    endtask
    task finalReport;
        $display("checks %0d errors %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #400000;
        errorCnt++;
        finalReport();
    end
    initial begin
        {oscSel, ioUpdate, abortIn, threeWire, lsb, rst_n} = 6'h20;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        `CHK("clkInEn", 1'b1, clkInEn)
        wr(`DDC_ADDR_TUNING, 32'hC123_4567, 32);
        `CHK("phaseHeld", 32'h0000_0000, phase)
        upd();
        p0 = phase;
        @(negedge clk) p1 = phase;
        `CHK("step", 32'hC123_4567, p1 - p0)
        rd(`DDC_ADDR_TUNING, 32);
        `CHK("tuningRd", 32'hC123_4567, got)
        wr(`DDC_ADDR_TUNING, 32'h0000_0000, 32);
        upd();
        p0 = phase;
        repeat (5) @(negedge clk);
        `CHK("hold", p0, phase)
        wr(`DDC_ADDR_CTRL1, 32'h0000_0014, 32);
        upd();
        `CHK("cleared", 32'h0000_0000, phase)
        `CHK("clkInOff", 1'b0, clkInEn)
        wr(`DDC_ADDR_CTRL1, 32'h0000_0000, 32);
        wr(`DDC_ADDR_TUNING, 32'h0000_1000, 32);
        upd();
        for (int i = 0; i < 6; i++) begin
            wr(`DDC_ADDR_CTRL2, (mv[i] << 3) | (i[0] ? 32'h200 : 32'h0), 24);
            upd();
            `CHK("mult", mv[i][4:0], mult)
            `CHK("pllEn", 1'(mv[i] >= 4 && mv[i] <= 20), pllEn)
            `CHK("xtalEn", i[0], xtalEn)
            `CHK("clkInEn", 1'b1, clkInEn)
        end
        oscSel = 1'b0;
        repeat (6) @(negedge clk);
        `CHK("oscOff", 2'h0, {oscEn, xtalEn})
        oscSel = 1'b1;
        repeat (6) @(negedge clk);
        `CHK("oscOn", 2'h3, {oscEn, xtalEn})
        wr(`DDC_ADDR_CTRL1, 32'h0000_0003, 32);
        upd();
        {lsb, threeWire} = 2'h3;
        wr(`DDC_ADDR_TUNING, 32'hA5C3_0F01, 32);
        upd();
        rd(`DDC_ADDR_TUNING, 32);
        `CHK("lsbRd", 32'hA5C3_0F01, got)
        fork
            wr(`DDC_ADDR_TUNING, 32'h1111_1111, 32);
            #600 @(negedge clk) abortIn = 1'b1;
        join
        abortIn = 1'b0;
        host.xfer(1'b0, lsb, {3'h0, `DDC_ADDR_TUNING}, 32'h2222_2222, 32, got);
        upd();
        rd(`DDC_ADDR_TUNING, 32);
        `CHK("aborted", 32'hA5C3_0F01, got)
        finalReport();
    end
endmodule // ddc_core_clock_select_tb
